// ---- src/cta_accumulator.sv ----
// calculated-time accumulator core
module cta_accumulator (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          distValid,
  input  wire logic [cta_pkg::STEP_W-1:0]    distStep,
  input  wire logic [cta_pkg::SPEED_W-1:0]   speedEntryA,
  input  wire logic [cta_pkg::SPEED_W-1:0]   speedEntryB,
  input  wire logic                          altSelSw,
  input  wire logic                          minusThouSw,
  input  wire logic                          mapSwapStored,
  input  wire logic                          speedChangeSw,
  input  wire logic                          selSpecial,
  input  wire logic                          mileTogSw,
  output logic      [cta_pkg::TIME_W-1:0]    calcTimeDisp,
  output logic      [cta_pkg::HUND_W-1:0]    odoDisp,
  output logic      [cta_pkg::SPEED_W-1:0]   speedDisp,
  output logic      [cta_pkg::TIME_W-1:0]    sectionEntry,
  output logic      [cta_pkg::CNT_W-1:0]     entryCount,
  output logic                               snapLamp,
  output logic                               mapSwapped
);
  import cta_pkg::*;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  cta_state_type                state;
  logic                         castPrev;
  logic                         milePrev;
  logic                         bootDone;
  logic                         snapMode;
  logic [HUND_W-1:0]            odoHund;
  logic [SUB_W-1:0]             odoSub;
  logic [HUND_W-1:0]            secHund;
  logic [SUB_W-1:0]             secSub;
  logic [SPEED_W-1:0]           secSpeed;
  logic                         runDirty;
  logic                         closePend;
  logic [NUM_W-1:0]             closeNum;
  logic [DEN_W-1:0]             closeDen;
  logic [NUM_W-1:0]             divNum;
  logic [DEN_W-1:0]             divDen;
  logic [DEN_W:0]               divRem;
  logic [NUM_W-1:0]             divQ;
  logic [DIV_CNT_W-1:0]         divCnt;
  logic [TIME_W-1:0]            closedSum;
  logic [TIME_W-1:0]            secTime;
  logic [TIME_W-1:0]            calcTime;

  logic                         castRise;
  logic                         mileRise;
  logic [SPEED_W-1:0]           rawSpeed;
  logic [SPEED_W-1:0]           activeSpeed;
  logic [SUB_W:0]               odoSum;
  logic [SUB_W:0]               secSum;
  logic [HUND_W-1:0]            next_odoHund;
  logic [SUB_W-1:0]             next_odoSub;
  logic [HUND_W-1:0]            next_secHund;
  logic [SUB_W-1:0]             next_secSub;
  logic [NUM_W-1:0]             fineDist;
  logic [NUM_W-1:0]             snapDist;
  logic [NUM_W-1:0]             runNum;
  logic [DEN_W-1:0]             runDen;
  logic [DEN_W:0]               remShift;
  logic                         remFits;
  logic                         divLast;

  assign castRise = rise(speedChangeSw, castPrev);
  assign mileRise = rise(mileTogSw, milePrev);

  // swap flag picks the other entry for the alternate switch
  assign rawSpeed = (altSelSw ^ mapSwapped) ? speedEntryB : speedEntryA;  // [RULE_10]
  // zero would make the divider return all ones, so it reads as the slowest legal speed
  assign activeSpeed = (rawSpeed < MIN_SPEED) ? MIN_SPEED : rawSpeed;  // [RULE_03]

  // fine distance carry into hundredths
  always_comb begin
    odoSum = {1'b0, odoSub};
    secSum = {1'b0, secSub};
    if (distValid) begin
      odoSum = odoSum + {5'h00, distStep};
      secSum = secSum + {5'h00, distStep};
    end
    next_odoHund = odoHund;
    next_odoSub = odoSum[SUB_W-1:0];
    if (odoSum >= {1'b0, FINE_PER_HUND}) begin
      next_odoHund = odoHund + 24'h000001;
      next_odoSub = SUB_W'(odoSum - {1'b0, FINE_PER_HUND});
    end
    next_secHund = secHund;
    next_secSub = secSum[SUB_W-1:0];
    if (secSum >= {1'b0, FINE_PER_HUND}) begin  // [RULE_01]
      next_secHund = secHund + 24'h000001;
      next_secSub = SUB_W'(secSum - {1'b0, FINE_PER_HUND});
    end
  end

  // numerators for the divider, fine resolution or snapped
  always_comb begin
    snapDist = NUM_W'({24'h000000, next_secHund} * FINE_PER_HUND_W);  // [RULE_04]
    fineDist = snapDist + {28'h0000000, next_secSub};  // [RULE_01]
    runNum = NUM_W'({24'h000000, secHund} * FINE_PER_HUND_W) + {28'h0000000, secSub};
    runNum = NUM_W'(runNum * TIME_MUL);  // [RULE_12]
    runDen = DEN_W'({16'h0000, secSpeed} * SPEED_SCALE);  // [RULE_12]
  end

  // one restoring step per clock
  assign remShift = {divRem[DEN_W-1:0], divNum[NUM_W-1]};
  assign remFits = remShift >= {1'b0, divDen};
  assign divLast = divCnt == DIV_STEPS - 6'h01;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      castPrev <= 1'b0;
      milePrev <= 1'b0;
    end else begin
      castPrev <= speedChangeSw;
      milePrev <= mileTogSw;
    end
  end

  // power-up strap caught in the first clocked cycle after release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bootDone <= 1'b0;
      mapSwapped <= 1'b0;
    end else if (!bootDone) begin
      bootDone <= 1'b1;
      mapSwapped <= mapSwapStored ^ (altSelSw & minusThouSw);  // [RULE_10]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      snapMode <= 1'b0;
    end else if (selSpecial && mileRise) begin
      snapMode <= ~snapMode;  // [RULE_06]
    end
  end

  // the lamp is the mode flop itself
  assign snapLamp = snapMode;  // [RULE_07]

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      odoHund <= '0;
      odoSub <= '0;
    end else begin
      odoHund <= next_odoHund;
      odoSub <= next_odoSub;
    end
  end

  // section distance; a change restarts it from zero, or from the carried fraction in snap mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      secHund <= '0;
      secSub <= '0;
    end else if (castRise) begin
      secHund <= '0;
      secSub <= snapMode ? next_secSub : '0;  // [RULE_05]
    end else begin
      secHund <= next_secHund;
      secSub <= next_secSub;
    end
  end

  // the active speed may be corrected after the fact; the old one closes the section
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      secSpeed <= MIN_SPEED;
    end else begin
      secSpeed <= activeSpeed;
    end
  end

  // closing job waits here while the divider is busy
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      closePend <= 1'b0;
      closeNum <= '0;
      closeDen <= '0;
    end else if (castRise) begin
      closePend <= 1'b1;
      closeNum <= NUM_W'((snapMode ? snapDist : fineDist) * TIME_MUL);  // [RULE_04]
      closeDen <= DEN_W'({16'h0000, secSpeed} * SPEED_SCALE);  // [RULE_12]
    end else if (state == CTA_IDLE) begin
      closePend <= 1'b0;
    end
  end

  // any change of distance or speed asks for a fresh running time
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runDirty <= 1'b1;
    end else if (distValid || castRise || activeSpeed != secSpeed) begin
      runDirty <= 1'b1;
    end else if (state == CTA_IDLE && !closePend) begin
      runDirty <= 1'b0;
    end
  end

  // shared divider; closing has priority over the running update
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= CTA_IDLE;
      divNum <= '0;
      divDen <= '0;
      divRem <= '0;
      divQ <= '0;
      divCnt <= '0;
    end else begin
      unique case (state)
        CTA_IDLE: begin
          divRem <= '0;
          divCnt <= '0;
          if (closePend && !castRise) begin
            state <= CTA_DIV_CLOSE;
            divNum <= closeNum;
            divDen <= closeDen;
          end else if (runDirty && !castRise) begin
            state <= CTA_DIV_RUN;
            divNum <= runNum;
            divDen <= runDen;
          end
        end
        CTA_DIV_RUN, CTA_DIV_CLOSE: begin
          divNum <= {divNum[NUM_W-2:0], 1'b0};
          divRem <= remFits ? remShift - {1'b0, divDen} : remShift;
          divQ <= {divQ[NUM_W-2:0], remFits};
          divCnt <= divCnt + 6'h01;
          if (divLast) begin
            state <= CTA_IDLE;
          end
        end
      endcase
    end
  end

  // finished sections are frozen entries added once to the closed sum
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      closedSum <= '0;
      sectionEntry <= '0;
      entryCount <= '0;
    end else if (state == CTA_DIV_CLOSE && divLast) begin
      closedSum <= closedSum + TIME_W'({divQ[NUM_W-2:0], remFits});  // [RULE_02]
      sectionEntry <= TIME_W'({divQ[NUM_W-2:0], remFits});  // [RULE_02]
      entryCount <= entryCount + 8'h01;
    end
  end

  // running section time; the new section includes any carried fraction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      secTime <= '0;
    end else if (state == CTA_DIV_CLOSE && divLast) begin
      secTime <= '0;
    end else if (state == CTA_DIV_RUN && divLast) begin
      secTime <= TIME_W'({divQ[NUM_W-2:0], remFits});  // [RULE_08]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      calcTime <= '0;
    end else begin
      calcTime <= closedSum + secTime;  // [RULE_08]
    end
  end

  // split: displays hold while the change switch is down
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      calcTimeDisp <= '0;
      odoDisp <= '0;
      speedDisp <= MIN_SPEED;
    end else if (!speedChangeSw) begin  // [RULE_09]
      calcTimeDisp <= calcTime;
      odoDisp <= odoHund;
      speedDisp <= secSpeed;
    end
  end
endmodule

// ---- src/cta_pkg.sv ----
// constants and types for the calculated-time accumulator
// Notes on behaviour
// [RULE_01] distance inside a section is kept to one hundred-millionth of a mile and time is computed from that.
// [RULE_02] a speed change stores the finished section's time as an entry that later sections never touch.
// [RULE_03] speeds down to one tenth of a mile per hour are accepted and time still advances correctly.
// [RULE_04] in snap mode the finished section's time is recomputed from distance cut to whole hundredths.
// [RULE_05] in snap mode the cut-off fraction of a hundredth starts the new section.
// [RULE_06] with the selector on special function, each whole-mile toggle flips snap mode.
// [RULE_07] the lamp between hundredths and thousandths is lit exactly while snap mode is on.
// [RULE_08] after a snapped change the running time includes the carried fraction at the new speed.
// [RULE_09] while the speed-change switch is held the displays hold still.
// [RULE_10] holding alternate-select and minus-thousandths at power-up swaps which speed entry is chosen.
// [RULE_11] the operator should change speed as the hundredths digit steps, most of all below 25 mph.
// [RULE_12] section time in minutes is miles times sixty over miles per hour.
package cta_pkg;
  localparam int HUND_W = 24;
  localparam int SUB_W = 20;
  localparam int STEP_W = 16;
  localparam int SPEED_W = 16;
  localparam int TIME_W = 24;
  localparam int NUM_W = 48;
  localparam int DEN_W = 32;
  localparam int CNT_W = 8;
  localparam int DIV_CNT_W = 6;
  // fine units of 1e-8 mile in one hundredth of a mile
  localparam logic [SUB_W-1:0] FINE_PER_HUND = 20'hf4240;
  localparam logic [NUM_W-1:0] FINE_PER_HUND_W = 48'h0000000f4240;
  // centiminutes = fine * 60 * 10 / (tenths mph * 1e6) = fine * 6 / (tenths * 10000)
  localparam logic [NUM_W-1:0] TIME_MUL = 48'h000000000006;
  localparam logic [DEN_W-1:0] SPEED_SCALE = 32'h00002710;
  localparam logic [SPEED_W-1:0] MIN_SPEED = 16'h0001;
  localparam logic [DIV_CNT_W-1:0] DIV_STEPS = 6'h30;
  typedef enum logic [1:0] {CTA_IDLE, CTA_DIV_RUN, CTA_DIV_CLOSE} cta_state_type;
endpackage

// ---- tb/cta_panel.sv ----
// front-panel switches and odometer pulse source
module cta_panel (
  input wire logic core_clk,
  output logic        distValid,
  output logic [15:0] distStep,
  output logic [15:0] speedEntryA,
  output logic [15:0] speedEntryB,
  output logic        altSelSw,
  output logic        minusThouSw,
  output logic        mapSwapStored,
  output logic        speedChangeSw,
  output logic        selSpecial,
  output logic        mileTogSw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {distValid, speedChangeSw, selSpecial, mileTogSw, mapSwapStored} = 5'h00;
    distStep = 16'h0000;
    speedEntryA = 16'h0064;
    speedEntryB = 16'h012c;
    altSelSw = 1'b1;
    minusThouSw = 1'b1;
  end
  // steps stay below one hundredth; idle step shows the inverse so stale data is not reused
  task automatic drive(input int n);
    repeat (n) begin
      @(negedge core_clk);
      distValid = 1'b1;
      distStep = 16'hc350;
      @(negedge core_clk);
      distValid = 1'b0;
      distStep = 16'h3caf;
    end
  endtask
  task automatic flip(input logic sp);
    @(negedge core_clk);
    selSpecial = sp;
    mileTogSw = 1'b1;
    @(negedge core_clk);
    mileTogSw = 1'b0;
    @(negedge core_clk);
    selSpecial = 1'b0;
  endtask
  task automatic hold(input logic v);
    @(negedge core_clk);
    speedChangeSw = v;
    repeat (2) @(negedge core_clk);
  endtask
  // power-up strap and stored swap state, set ahead of a reset so both stand at its release
  task automatic strap(input logic stored, input logic [15:0] b);
    @(negedge core_clk);
    mapSwapStored = stored;
    altSelSw = 1'b1;
    minusThouSw = 1'b1;
    speedEntryB = b;
  endtask
  task automatic sw(input logic alt, input logic [15:0] a);
    @(negedge core_clk);
    altSelSw = alt;
    minusThouSw = 1'b0;
    speedEntryA = a;
  endtask
endmodule

// ---- tb/cta_properties.sv ----
// port-level assertions for the calculated-time accumulator
module cta_properties (
  input wire logic                         core_clk,
  input wire logic                         nrst,
  input wire logic                         speedChangeSw,
  input wire logic                         selSpecial,
  input wire logic                         mileTogSw,
  input wire logic [cta_pkg::TIME_W-1:0]   calcTimeDisp,
  input wire logic [cta_pkg::HUND_W-1:0]   odoDisp,
  input wire logic [cta_pkg::TIME_W-1:0]   sectionEntry,
  input wire logic [cta_pkg::CNT_W-1:0]    entryCount,
  input wire logic                         snapLamp,
  input wire logic                         mapSwapped
);
  timeunit 1ns;
  timeprecision 1ps;
  import cta_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // one spare edge allowed in case the toggle is flopped before use
  lamp_flip_a: assert property ($rose(mileTogSw) && selSpecial |=> ##[0:1] $changed(snapLamp))
    else $error("snap lamp did not follow toggle");
  lamp_hold_a: assert property (!selSpecial [*2] |=> $stable(snapLamp))
    else $error("snap lamp moved without toggle");
  odo_freeze_a: assert property (speedChangeSw |=> $stable(odoDisp))
    else $error("odometer moved while split");
  time_freeze_a: assert property (speedChangeSw [*2] |-> $stable(calcTimeDisp))
    else $error("calculated time moved while split");
  count_step_a: assert property ($changed(entryCount) |-> entryCount == $past(entryCount) + 8'h01)
    else $error("entry count skipped");
  entry_fixed_a: assert property ($stable(entryCount) |-> $stable(sectionEntry))
    else $error("stored entry altered");
  close_done_a: assert property ($rose(speedChangeSw) |-> ##[1:160] $changed(entryCount))
    else $error("section not stored");
  swap_keep_a: assert property ($past(nrst) |=> $stable(mapSwapped))
    else $error("mapping changed after power-up");
  cover property ($rose(speedChangeSw) && snapLamp);
  cover property ($rose(snapLamp));
  cover property ($changed(entryCount));
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the calculated-time accumulator
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cta_pkg::*;
  localparam logic [15:0] STEP = 16'hc350;
  localparam logic [15:0] SPD_A = 16'h0064;
  localparam logic [15:0] SPD_B = 16'h012c;
  logic core_clk, nrst, distValid, altSelSw, minusThouSw, mapSwapStored, speedChangeSw, selSpecial, mileTogSw;
  logic [15:0] distStep, speedEntryA, speedEntryB, speedDisp;
  logic [TIME_W-1:0] calcTimeDisp, sectionEntry;
  logic [HUND_W-1:0] odoDisp;
  logic [CNT_W-1:0] entryCount;
  logic snapLamp, mapSwapped;
  logic [31:0] base;
  int error_cnt = 0;
  int n_tests = 0;
  cta_panel i_cta_panel (.core_clk(core_clk), .distValid(distValid), .distStep(distStep),
    .speedEntryA(speedEntryA), .speedEntryB(speedEntryB), .altSelSw(altSelSw), .minusThouSw(minusThouSw),
    .mapSwapStored(mapSwapStored), .speedChangeSw(speedChangeSw), .selSpecial(selSpecial), .mileTogSw(mileTogSw));
  cta_accumulator i_cta_accumulator (.core_clk(core_clk), .nrst(nrst), .distValid(distValid), .distStep(distStep),
    .speedEntryA(speedEntryA), .speedEntryB(speedEntryB), .altSelSw(altSelSw), .minusThouSw(minusThouSw),
    .mapSwapStored(mapSwapStored), .speedChangeSw(speedChangeSw), .selSpecial(selSpecial), .mileTogSw(mileTogSw),
    .calcTimeDisp(calcTimeDisp), .odoDisp(odoDisp), .speedDisp(speedDisp), .sectionEntry(sectionEntry),
    .entryCount(entryCount), .snapLamp(snapLamp), .mapSwapped(mapSwapped));
  // centiminutes for p pulses at t tenths of mph, floored per section
  function automatic logic [31:0] ct(input logic [15:0] p, input logic [15:0] t);
    return 32'({32'h0, p} * {32'h0, STEP} * TIME_MUL / ({32'h0, t} * {16'h0, SPEED_SCALE}));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // divider runs ~50 cycles, twice over when a close is pending
  task automatic settle();
    repeat (300) @(negedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    check(32'(speedDisp), 32'h00000001);
    check(32'(calcTimeDisp), 32'h00000000);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    i_cta_panel.sw(1'b0, SPD_A);
    check(32'(mapSwapped), 32'h00000001);
    i_cta_panel.flip(1'b1);
    check(32'(snapLamp), 32'h00000001);
    i_cta_panel.flip(1'b0);
    check(32'(snapLamp), 32'h00000001);
    i_cta_panel.flip(1'b1);
    check(32'(snapLamp), 32'h00000000);
    i_cta_panel.drive(16'h07da);
    settle();
    check(32'(odoDisp), 32'h00000064);
    check(32'(calcTimeDisp), ct(16'h07da, SPD_B));
    check(32'(speedDisp), 32'(SPD_B));
    // close on an exact hundredth, as an operator should
    i_cta_panel.drive(16'h000a);
    settle();
    base = ct(16'h07e4, SPD_B);
    check(32'(calcTimeDisp), base);
    i_cta_panel.hold(1'b1);
    i_cta_panel.drive(16'h0014);
    check(32'(odoDisp), 32'h00000065);
    i_cta_panel.hold(1'b0);
    settle();
    check(32'(sectionEntry), base);
    check(32'(entryCount), 32'h00000001);
    check(32'(odoDisp), 32'h00000066);
    i_cta_panel.sw(1'b1, SPD_A);
    i_cta_panel.drive(16'h010e);
    settle();
    check(32'(calcTimeDisp), base + ct(16'h0122, SPD_A));
    i_cta_panel.flip(1'b1);
    i_cta_panel.hold(1'b1);
    i_cta_panel.hold(1'b0);
    i_cta_panel.sw(1'b0, SPD_A);
    settle();
    base = base + ct(16'h0118, SPD_A);
    check(32'(sectionEntry), ct(16'h0118, SPD_A));
    check(32'(entryCount), 32'h00000002);
    check(32'(calcTimeDisp), base + ct(16'h000a, SPD_B));
    i_cta_panel.sw(1'b1, 16'h0001);
    settle();
    check(32'(calcTimeDisp), base + ct(16'h000a, 16'h0001));
    i_cta_panel.drive(16'h0001);
    settle();
    check(32'(calcTimeDisp), base + ct(16'h000b, 16'h0001));
    check(32'(sectionEntry), ct(16'h0118, SPD_A));
    check(32'(odoDisp), 32'h00000073);
    // second power-up with the strap held and a swap already stored: default mapping returns
    i_cta_panel.strap(1'b1, 16'h0258);
    nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    check(32'(entryCount), 32'h00000000);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    check(32'(mapSwapped), 32'h00000000);
    check(32'(snapLamp), 32'h00000000);
    i_cta_panel.sw(1'b1, SPD_A);
    i_cta_panel.drive(16'h0014);
    settle();
    check(32'(speedDisp), 32'h00000258);
    check(32'(odoDisp), 32'h00000001);
    check(32'(calcTimeDisp), ct(16'h0014, 16'h0258));
    finish_test();
  end
endmodule
bind cta_accumulator cta_properties i_cta_properties (.core_clk(core_clk), .nrst(nrst),
  .speedChangeSw(speedChangeSw), .selSpecial(selSpecial), .mileTogSw(mileTogSw), .calcTimeDisp(calcTimeDisp),
  .odoDisp(odoDisp), .sectionEntry(sectionEntry), .entryCount(entryCount), .snapLamp(snapLamp),
  .mapSwapped(mapSwapped));
